// [pkg/flash_addr_consts.svh]
// Purpose: shared constants for the flash address and unit select block
// Assumes: one target, two logical units, 8-bit command/address bus
// Notes: no timescale here, definitions only
//
// Summary of operation
// - double-rate modes force column bit zero low; odd column is flagged
// - row-only commands such as erase expect no column cycles
// - first address cycle holds least significant bits, last holds most
// - row holds page low, block in middle, unit index on top
// - plane selector is the lowest bits of the block field
// - unit status select disables output of every other unit
// - status select leaves page register choice to last read command
// - program setup without prior 11h may clear idle unit registers
`ifndef FLASH_ADDR_CONSTS_SVH
`define FLASH_ADDR_CONSTS_SVH

// ==========================================================
// address layout
`define COL_BITS 16
`define ROW_BITS 24
`define PAGE_BITS 7
`define BLOCK_BITS 16
`define PAGE_LSB 0
`define BLOCK_LSB 7
`define LUN_LSB 23
`define NUM_LUN 2
`define PLANE_BITS 2
`define NUM_PLANE 4
`define COL_CYCLES 3'h2
`define ROW_CYCLES 3'h3

// ==========================================================
// commands
`define CMD_READ 8'h00
`define CMD_READ_GO 8'h30
`define CMD_READ_CACHE 8'h31
`define CMD_READ_MP 8'h32
`define CMD_COPY_READ 8'h35
`define CMD_PROG 8'h80
`define CMD_PROG_B 8'h81
`define CMD_PROG_C 8'h85
`define CMD_PROG_GO 8'h10
`define CMD_PROG_MP 8'h11
`define CMD_PROG_CACHE 8'h15
`define CMD_ERASE 8'h60
`define CMD_ERASE_GO 8'hD0
`define CMD_ERASE_MP 8'hD1
`define CMD_STATUS_SEL 8'h78
`define CMD_COL_MOVE 8'h05
`define CMD_COL_MOVE_ENH 8'h06

// ==========================================================
// restriction modes and reset values
`define RESTRICT_NONE 2'h0
`define RESTRICT_FULL 2'h1
`define RESTRICT_XNOR 2'h2
`define RST_LUN_EN 2'h1

`endif

// [pkg/flash_addr_pkg.sv]
// Purpose: types for the flash address and unit select block
// Assumes: constants header is reachable by bare name
// Notes: types only
`include "flash_addr_consts.svh"
package flash_addr_pkg;
    typedef logic [`COL_BITS-1:0] col_t;
    typedef logic [`ROW_BITS-1:0] row_t;
    typedef logic [`NUM_LUN-1:0] lun_vec_t;
    typedef logic [`PLANE_BITS-1:0] plane_t;
    typedef logic [`BLOCK_BITS-1:0] block_t;
    typedef logic [`PAGE_BITS-1:0] page_t;
    typedef enum {ST_IDLE, ST_ADDR, ST_CONFIRM} state_t;
    typedef enum {OP_NONE, OP_READ, OP_PROG, OP_ERASE, OP_STATUS_SEL,
        OP_COL_MOVE, OP_COL_MOVE_ENH} op_t;
endpackage

// [pkg/addr_cycle_if.sv]
// Purpose: carrier between command decode and address cycle collector
// Assumes: single clock domain
// Notes: start and done are one-cycle pulses
`timescale 1ns/10ps
interface addr_cycle_if;
    import flash_addr_pkg::*;
    logic start;
    logic withCol;
    logic withRow;
    logic strobe;
    logic [7:0] data;
    logic done;
    col_t col;
    row_t row;
    modport collector
    (
        input start, withCol, withRow, strobe, data,
        output done, col, row
    );
    modport decoder
    (
        output start, withCol, withRow, strobe, data,
        input done, col, row
    );
endinterface

// [src/addr_cycle_collector.sv]
// Purpose: gathers column then row address bytes into words
// Assumes: strobe is one cycle per address byte
// Notes: a new start aborts any sequence in progress
`timescale 1ns/10ps
module addr_cycle_collector
(
    input wire logic clk,
    input wire logic rst_n,
    addr_cycle_if.collector ac
);
    import flash_addr_pkg::*;

    // ==========================================================
    // cycle counting
    logic busy;
    logic [2:0] colLeft;
    logic [2:0] rowLeft;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
            colLeft <= 3'h0;
            rowLeft <= 3'h0;
        end
        else if (ac.start)
        begin
            busy <= ac.withCol | ac.withRow;
            colLeft <= ac.withCol ? `COL_CYCLES : 3'h0;
            rowLeft <= ac.withRow ? `ROW_CYCLES : 3'h0;
        end
        else if (busy && ac.strobe)
        begin
            if (colLeft != 3'h0)
                colLeft <= colLeft - 3'h1;
            else
                rowLeft <= rowLeft - 3'h1;
            if ((colLeft + rowLeft) == 3'h1)
                busy <= 1'b0;
        end
    end

    // ==========================================================
    // byte shifting, first byte ends lowest
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ac.col <= '0;
            ac.row <= '0;
        end
        else if (ac.start)
        begin
            ac.col <= '0;
            ac.row <= '0;
        end
        else if (busy && ac.strobe)
        begin
            if (colLeft != 3'h0)
                ac.col <= {ac.data, ac.col[`COL_BITS-1:8]};
            else
                ac.row <= {ac.data, ac.row[`ROW_BITS-1:8]};
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ac.done <= 1'b0;
        else
            ac.done <= busy && ac.strobe && !ac.start &&
                ((colLeft + rowLeft) == 3'h1);
    end
endmodule

// [src/flash_address_lun_select.sv]
// Purpose: command decode, row field split and unit output selection
// Assumes: latch strobes are one cycle wide and synchronous to ref_clk
// Notes: host-side ordering is checked only where flags are cheap
`timescale 1ns/10ps
module flash_address_lun_select
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic [7:0] busIn,
    input wire logic doubleRateMode,
    input wire logic regClearEnable,
    input wire logic [1:0] restrictMode,
    input wire flash_addr_pkg::lun_vec_t lunBusy,
    output flash_addr_pkg::col_t colAddr,
    output flash_addr_pkg::page_t pageAddr,
    output flash_addr_pkg::block_t blockAddr,
    output logic lunAddr,
    output flash_addr_pkg::plane_t planeSel,
    output logic addrReady,
    output logic colOddError,
    output flash_addr_pkg::lun_vec_t lunOutEn,
    output flash_addr_pkg::lun_vec_t pageRegSel,
    output flash_addr_pkg::lun_vec_t pageRegClear,
    output logic planeRepeat,
    output logic blockConflict
);
    import flash_addr_pkg::*;

    addr_cycle_if ac();
    state_t state;
    op_t op;
    op_t next_op;
    logic next_col;
    logic next_row;
    logic prevWasMp;
    logic [`NUM_PLANE-1:0] planeUsed;
    block_t firstBlock;
    plane_t firstPlane;
    row_t row;
    plane_t rowPlane;
    block_t rowBlock;
    logic restricted;

    // ==========================================================
    // command decode
    always_comb
    begin
        next_op = OP_NONE;
        next_col = 1'b0;
        next_row = 1'b0;
        case (busIn)
            `CMD_READ:
            begin
                next_op = OP_READ;
                next_col = 1'b1;
                next_row = 1'b1;
            end
            `CMD_PROG, `CMD_PROG_B, `CMD_PROG_C:
            begin
                next_op = OP_PROG;
                next_col = 1'b1;
                next_row = 1'b1;
            end
            `CMD_ERASE:
            begin
                next_op = OP_ERASE;
                next_row = 1'b1;
            end
            `CMD_STATUS_SEL:
            begin
                next_op = OP_STATUS_SEL;
                next_row = 1'b1;
            end
            `CMD_COL_MOVE:
            begin
                next_op = OP_COL_MOVE;
                next_col = 1'b1;
            end
            `CMD_COL_MOVE_ENH:
            begin
                next_op = OP_COL_MOVE_ENH;
                next_col = 1'b1;
                next_row = 1'b1;
            end
            default:
            begin
                next_op = OP_NONE;
            end
        endcase
    end

    assign ac.start = cmdLatch && (next_op != OP_NONE);
    assign ac.withCol = next_col;
    assign ac.withRow = next_row;
    assign ac.strobe = addrLatch;
    assign ac.data = busIn;

    addr_cycle_collector u_collector
    (
        .clk(ref_clk),
        .rst_n(rst_n),
        .ac(ac.collector)
    );

    // ==========================================================
    // row field split
    assign row = ac.row;
    assign rowBlock = row[`LUN_LSB-1:`BLOCK_LSB];
    assign rowPlane = rowBlock[`PLANE_BITS-1:0];

    always_comb
    begin
        restricted = 1'b0;
        case (restrictMode)
            `RESTRICT_FULL: restricted = 1'b1;
            `RESTRICT_XNOR:
                restricted = ~(firstPlane[0] ^ rowPlane[0]);
            default: restricted = 1'b0;
        endcase
    end

    // ==========================================================
    // sequence state
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            op <= OP_NONE;
        end
        else if (ac.start)
        begin
            state <= ST_ADDR;
            op <= next_op;
        end
        else
        begin
            case (state)
                ST_IDLE: state <= ST_IDLE;
                ST_ADDR:
                begin
                    if (ac.done)
                        state <= (op == OP_READ || op == OP_PROG ||
                            op == OP_ERASE) ? ST_CONFIRM : ST_IDLE;
                end
                ST_CONFIRM:
                begin
                    if (cmdLatch)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            prevWasMp <= 1'b0;
        else if (cmdLatch)
            prevWasMp <= (busIn == `CMD_PROG_MP);
    end

    // ==========================================================
    // captured address fields
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            colAddr <= '0;
            colOddError <= 1'b0;
        end
        else if (ac.done && op != OP_ERASE && op != OP_STATUS_SEL)
        begin
            colAddr <= {ac.col[`COL_BITS-1:1],
                ac.col[0] & ~doubleRateMode};
            colOddError <= doubleRateMode & ac.col[0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pageAddr <= '0;
            blockAddr <= '0;
            lunAddr <= 1'b0;
            planeSel <= '0;
        end
        else if (ac.done && op != OP_COL_MOVE)
        begin
            pageAddr <= row[`BLOCK_LSB-1:`PAGE_LSB];
            blockAddr <= rowBlock;
            lunAddr <= row[`LUN_LSB];
            planeSel <= rowPlane;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            addrReady <= 1'b0;
        else
            addrReady <= ac.done;
    end

    // ==========================================================
    // unit output path selection
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            lunOutEn <= `RST_LUN_EN;
        else if (ac.done && (op == OP_STATUS_SEL || op == OP_COL_MOVE_ENH))
        begin
            for (int i = 0; i < `NUM_LUN; i++)
                lunOutEn[i] <= (row[`LUN_LSB] == i[0]);
        end
    end

    // page register choice per unit, untouched by status select
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pageRegSel <= '0;
        else if (state == ST_CONFIRM && cmdLatch && op == OP_READ)
        begin
            if (busIn == `CMD_READ_GO || busIn == `CMD_COPY_READ)
                pageRegSel[lunAddr] <= 1'b0;
            else if (busIn == `CMD_READ_CACHE)
                pageRegSel[lunAddr] <= 1'b1;
        end
    end

    // idle units drop their page register on a fresh 80h program setup while regClearEnable is low
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            pageRegClear <= '0;
        else if (cmdLatch && busIn == `CMD_PROG && !prevWasMp &&
            !regClearEnable)
            pageRegClear <= ~lunBusy;
        else
            pageRegClear <= '0;
    end

    // ==========================================================
    // multi-plane bookkeeping
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            planeUsed <= '0;
            firstBlock <= '0;
            firstPlane <= '0;
            planeRepeat <= 1'b0;
            blockConflict <= 1'b0;
        end
        else if (ac.done && (op == OP_READ || op == OP_PROG ||
            op == OP_ERASE))
        begin
            if (planeUsed == '0)
            begin
                firstBlock <= rowBlock;
                firstPlane <= rowPlane;
                planeRepeat <= 1'b0;
                blockConflict <= 1'b0;
            end
            else
            begin
                if (planeUsed[rowPlane])
                    planeRepeat <= 1'b1;
                if (restricted && (firstBlock[`BLOCK_BITS-1:`PLANE_BITS] !=
                    rowBlock[`BLOCK_BITS-1:`PLANE_BITS]))
                    blockConflict <= 1'b1;
            end
            planeUsed[rowPlane] <= 1'b1;
        end
        else if (state == ST_CONFIRM && cmdLatch &&
            busIn != `CMD_PROG_MP && busIn != `CMD_READ_MP &&
            busIn != `CMD_ERASE_MP)
            planeUsed <= '0;
    end
endmodule

// [tb/flash_host_model.sv]
// Purpose: host side model driving command and address cycles
// Assumes: bytes change on the falling edge of ref_clk
// Notes: idle bus shows the inverse of the last byte
`timescale 1ns/10ps
module flash_host_model
(
    input wire logic ref_clk,
    output logic cmdLatch,
    output logic addrLatch,
    output logic [7:0] busIn
);
    initial
    begin
        cmdLatch = 1'b0;
        addrLatch = 1'b0;
        busIn = 8'hA5;
    end
    // ==========================================================
    // command then n address bytes, back to back, lsb byte first
    task automatic op(input logic [7:0] c, input logic [39:0] a, input int n);
        int i;
        @(negedge ref_clk);
        cmdLatch = 1'b1;
        busIn = c;
        for (i = 0; i < n; i++)
        begin
            @(negedge ref_clk);
            cmdLatch = 1'b0;
            addrLatch = 1'b1;
            busIn = a[8*i +: 8];
        end
        @(negedge ref_clk);
        cmdLatch = 1'b0;
        addrLatch = 1'b0;
        busIn = ~busIn;
    endtask
endmodule

// [tb/flash_addr_asserts.sv]
// Purpose: port level checks of the address and unit select block
// Assumes: one clock domain
// Notes: bound to the top module below
`timescale 1ns/10ps
module flash_addr_asserts
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic [7:0] busIn,
    input wire logic doubleRateMode,
    input wire logic regClearEnable,
    input wire flash_addr_pkg::lun_vec_t lunBusy,
    input wire flash_addr_pkg::lun_vec_t lunOutEn,
    input wire flash_addr_pkg::col_t colAddr,
    input wire flash_addr_pkg::block_t blockAddr,
    input wire logic lunAddr,
    input wire logic addrReady,
    input wire flash_addr_pkg::plane_t planeSel,
    input wire flash_addr_pkg::lun_vec_t pageRegSel,
    input wire flash_addr_pkg::lun_vec_t pageRegClear
);
    import flash_addr_pkg::*;
    logic [7:0] lastCmd;
    logic progReq;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            lastCmd <= 8'h00;
        else if (cmdLatch)
            lastCmd <= busIn;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            progReq <= 1'b0;
        else
            progReq <= cmdLatch && busIn == 8'h80 && lastCmd != 8'h11
                && !regClearEnable;
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence rowOnly;
        cmdLatch && (busIn == 8'h60 || busIn == 8'h78) ##1 addrLatch [*3];
    endsequence
    sequence colAndRow;
        cmdLatch && busIn == 8'h00 ##1 addrLatch [*5];
    endsequence
    a_row_ready_delay: assert property (rowOnly |-> ##2 addrReady)
        else $error("row only capture late");
    a_full_ready_delay: assert property
        (colAndRow |-> ##2 addrReady)
        else $error("column and row capture late");
    a_ready_one_cycle: assert property (addrReady |=> !addrReady)
        else $error("ready pulse too long");
    a_plane_from_block: assert property
        (planeSel == blockAddr[1:0])
        else $error("plane not block low bits");
    a_even_column: assert property
        (addrReady && doubleRateMode |-> !colAddr[0])
        else $error("odd column in double rate mode");
    a_single_output: assert property ($onehot(lunOutEn))
        else $error("output enable not one hot");
    a_select_unit: assert property
        (addrReady && (lastCmd == 8'h78 || lastCmd == 8'h06)
        |-> lunOutEn == (lunAddr ? 2'h2 : 2'h1))
        else $error("selected unit not enabled");
    a_select_keeps_reg: assert property
        (addrReady && lastCmd == 8'h78 |-> $stable(pageRegSel))
        else $error("status select moved register choice");
    a_confirm_sets_reg: assert property
        (cmdLatch && (busIn == 8'h30 || busIn == 8'h31)
        |=> pageRegSel[lunAddr] == $past(busIn[0]))
        else $error("read confirm register choice wrong");
    a_clear_idle_units: assert property
        (progReq |-> pageRegClear == ~$past(lunBusy))
        else $error("program setup clear wrong");
    a_clear_cause: assert property
        (pageRegClear != 2'h0 |-> progReq)
        else $error("register clear without cause");
endmodule
bind flash_address_lun_select flash_addr_asserts u_asserts
(
    .ref_clk(ref_clk), .rst_n(rst_n), .cmdLatch(cmdLatch),
    .addrLatch(addrLatch), .busIn(busIn), .doubleRateMode(doubleRateMode),
    .regClearEnable(regClearEnable), .lunBusy(lunBusy), .lunOutEn(lunOutEn),
    .colAddr(colAddr), .blockAddr(blockAddr), .lunAddr(lunAddr),
    .addrReady(addrReady), .planeSel(planeSel), .pageRegSel(pageRegSel),
    .pageRegClear(pageRegClear)
);

// [tb/testbench.sv]
// Purpose: self checking bench for the address and unit select block
// Assumes: host model drives the command and address bus
// Notes: random values from a fixed seed shift register
`timescale 1ns/10ps
`include "flash_addr_consts.svh"
module testbench;
    import flash_addr_pkg::*;
    logic ref_clk, rst_n, doubleRateMode, regClearEnable;
    logic cmdLatch, addrLatch, lunAddr, addrReady, colOddError;
    logic planeRepeat, blockConflict;
    logic [7:0] busIn, c;
    logic [1:0] restrictMode;
    lun_vec_t lunBusy, lunOutEn, pageRegSel, pageRegClear, keepSel;
    col_t colAddr, col, keepCol;
    row_t row, row2;
    page_t pageAddr;
    block_t blockAddr;
    plane_t planeSel;
    int errors, total_checks, i;
    logic [31:0] seed;
    flash_host_model u_host (.ref_clk(ref_clk), .cmdLatch(cmdLatch),
        .addrLatch(addrLatch), .busIn(busIn));
    flash_address_lun_select u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .cmdLatch(cmdLatch), .addrLatch(addrLatch), .busIn(busIn),
        .doubleRateMode(doubleRateMode), .regClearEnable(regClearEnable),
        .restrictMode(restrictMode), .lunBusy(lunBusy), .colAddr(colAddr),
        .pageAddr(pageAddr), .blockAddr(blockAddr), .lunAddr(lunAddr),
        .planeSel(planeSel), .addrReady(addrReady), .colOddError(colOddError),
        .lunOutEn(lunOutEn), .pageRegSel(pageRegSel),
        .pageRegClear(pageRegClear), .planeRepeat(planeRepeat),
        .blockConflict(blockConflict));
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        int k;
        for (k = 0; k < 32; k++)
            s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction
    function automatic logic expConflict(input logic [1:0] m,
        input block_t a, input block_t b);
        logic up;
        up = a[15:2] != b[15:2];
        return m == 2'h1 ? up : (m == 2'h2 ? up && (a[0] ~^ b[0]) : 1'b0);
    endfunction
    task automatic chk(input string n, input logic [23:0] e,
        input logic [23:0] g);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic waitReady;
        int k;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (addrReady !== 1'b1 && k < 8);
        if (addrReady !== 1'b1)
        begin
            $display("[FAIL] addrReady expected 1 seen %b", addrReady);
            errors++;
            complete_run();
        end
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        errors = 0;
        total_checks = 0;
        seed = 32'hCED9;
        rst_n = 1'b0;
        doubleRateMode = 1'b0;
        regClearEnable = 1'b0;
        restrictMode = 2'h0;
        lunBusy = 2'h0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        @(posedge ref_clk);
        #1;
        chk("outEn reset", 24'h1, lunOutEn);
        for (i = 0; i < 16; i++)
        begin
            @(negedge ref_clk);
            seed = lfsr(seed);
            col = i == 0 ? 16'hFFFF : (i == 1 ? 16'h0001 : seed[15:0]);
            row = i == 0 ? 24'hFFFFFF : seed[31:8];
            doubleRateMode = (i < 2) || seed[3];
            u_host.op(8'h00, {row, col},
                `COL_CYCLES + `ROW_CYCLES);
            waitReady();
            chk("col", {col[15:1], col[0] & !doubleRateMode}, colAddr);
            chk("oddErr", col[0] & doubleRateMode, colOddError);
            chk("page", row[6:0], pageAddr);
            chk("block", row[22:7], blockAddr);
            chk("unit", row[23], lunAddr);
            chk("plane", row[8:7], planeSel);
            c = seed[4] ? 8'h31 : 8'h30;
            u_host.op(c, 40'h0, 0);
            @(posedge ref_clk);
            #1;
            chk("regSel", c[0], pageRegSel[row[23]]);
        end
        for (i = 0; i < 4; i++)
        begin
            @(negedge ref_clk);
            doubleRateMode = 1'b0;
            lunBusy = 2'h0;
            seed = lfsr(seed);
            row = {i[1], seed[22:0]};
            keepCol = colAddr;
            keepSel = pageRegSel;
            c = i[0] ? 8'h06 : 8'h78;
            u_host.op(c, i[0] ? {row, seed[31:16]} : {16'h0, row},
                i[0] ? `COL_CYCLES + `ROW_CYCLES : `ROW_CYCLES);
            waitReady();
            chk("outEn", i[1] ? 24'h2 : 24'h1, lunOutEn);
            chk("keepSel", keepSel, pageRegSel);
            chk("col", i[0] ? seed[31:16] : keepCol, colAddr);
        end
        @(negedge ref_clk);
        seed = lfsr(seed);
        keepSel = lunOutEn;
        u_host.op(8'h05, {24'h0, seed[15:0]}, `COL_CYCLES);
        waitReady();
        chk("moveCol", seed[15:0], colAddr);
        chk("moveOutEn", keepSel, lunOutEn);
        chk("moveUnit", 24'h1, lunAddr);
        for (i = 0; i < 4; i++)
        begin
            @(negedge ref_clk);
            seed = lfsr(seed);
            lunBusy = seed[1:0];
            regClearEnable = i == 2;
            if (i == 1)
                u_host.op(8'h11, 40'h0, 0);
            u_host.op(i == 3 ? 8'h81 : 8'h80, 40'h0, 0);
            #1;
            chk("clear", i == 0 ? {22'h0, ~lunBusy} : 24'h0,
                pageRegClear);
        end
        for (i = 0; i < 8; i++)
        begin
            @(negedge ref_clk);
            regClearEnable = 1'b0;
            seed = lfsr(seed);
            restrictMode = i[1:0];
            row = {1'b0, seed[22:0]};
            row2 = {1'b0, seed[5] ? row[22:9] : seed[31:18], seed[7:6],
                seed[30:24]};
            keepCol = colAddr;
            u_host.op(8'hD0, 40'h0, 0);
            u_host.op(8'h60, {16'h0, row}, 3);
            waitReady();
            u_host.op(8'hD1, 40'h0, 0);
            u_host.op(8'h60, {16'h0, row2}, 3);
            waitReady();
            @(posedge ref_clk);
            #1;
            chk("repeat", row[8:7] == row2[8:7], planeRepeat);
            chk("conflict", expConflict(restrictMode, row[22:7], row2[22:7]),
                blockConflict);
            chk("keepCol", keepCol, colAddr);
        end
        complete_run();
    end
endmodule
